// ### verilog/bxs_sequencer.sv
// Bridge excitation sequencer: square-wave drive, sampling window and
// synchronous detection for a delta-sigma bridge converter.
// Assumes mode inputs and samples come from logic on mclk; only the
// first excitation pin arrives from outside and is synchronised here.
//
// Functional notes
// - ac mode drives a square wave at an integer sub-multiple of mclk.
// - ac mode demodulates samples against the square-wave polarity.
// - after each polarity change, sampling waits 64 master clock cycles.
// - internal, select zero: switching stops, second output high, first low.
// - external excitation: second output follows the first pin, except in sleep.
// - sleep drives first output high, second low, in any mode.
// - six output words are unsettled after each polarity change.
// - after reset the first output is driven low.
// - select one gives 1 kHz from a 4.096 MHz master clock.
`timescale 1ns/1ps
module bxs_sequencer
  import bxs_pkg::*;
#(
  parameter logic [CNT_W-1:0] HALF_P1 = HALF_SEL1,
  parameter logic [CNT_W-1:0] HALF_P2 = HALF_SEL2,
  parameter logic [CNT_W-1:0] HALF_P3 = HALF_SEL3
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Mode control
  input wire logic sleep,
  input wire logic ext_sel,
  input wire logic ac_mode,
  input wire logic [1:0] excitation_select_field,
  // Excitation pins; the first is two-way
  input wire logic excitation_a_in,
  output logic excitation_out_a,
  output logic excitation_a_oe_n,
  output logic excitation_out_b,
  // Converter samples in, detected samples out
  input wire bxs_sample_s raw_sample,
  output bxs_sample_s det_sample,
  output logic det_settled,
  output logic polarity,
  output logic sample_window
);

  bxs_mode_e mode;
  bxs_mode_e next_mode;
  logic pol;
  logic [CNT_W-1:0] phase_cnt;
  logic [CNT_W-1:0] half_len;
  logic [HOLD_W-1:0] hold_cnt;
  logic [2:0] settle_cnt;
  logic a_sync;
  logic a_prev;
  logic flip;
  logic pol_evt;
  logic demod;

  bxs_sync #(.W(1)) u_pin_sync (
    .mclk(mclk),
    .rst(rst),
    .d(excitation_a_in),
    .q(a_sync)
  );

  always_comb begin
    if (sleep) begin
      next_mode = ST_SLEEP;
    end else if (ext_sel) begin
      next_mode = ST_EXT;
    end else if (!ac_mode || excitation_select_field == SEL_STOP) begin
      next_mode = ST_HOLD;
    end else begin
      next_mode = ST_ACTIVE;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode <= ST_HOLD;
    end else begin
      mode <= next_mode;
    end
  end

  always_comb begin
    unique case (excitation_select_field)
      // Select zero holds the wave, so its length is never used
      2'h0, 2'h1: half_len = HALF_P1;
      2'h2: half_len = HALF_P2;
      2'h3: half_len = HALF_P3;
    endcase
  end

  // Same reload for both halves keeps them equal
  assign flip = (mode == ST_ACTIVE) && (phase_cnt == '0);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pol <= POL_RESET;
      phase_cnt <= '0;
    end else if (mode != ST_ACTIVE) begin
      pol <= POL_RESET;
      phase_cnt <= half_len - 16'h0001;
    end else if (flip) begin
      pol <= ~pol;
      phase_cnt <= half_len - 16'h0001;
    end else begin
      phase_cnt <= phase_cnt - 16'h0001;
    end
  end

  // External edges count as polarity changes too
  always_ff @(posedge mclk) begin
    if (rst) begin
      a_prev <= 1'b0;
    end else begin
      a_prev <= a_sync;
    end
  end

  assign pol_evt = flip || ((mode == ST_EXT) && (a_sync != a_prev));

  always_ff @(posedge mclk) begin
    if (rst) begin
      hold_cnt <= '0;
    end else if (pol_evt || mode == ST_SLEEP) begin
      hold_cnt <= HOLDOFF_CYC;
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 7'h01;
    end
  end

  assign sample_window = (hold_cnt == '0) && (mode != ST_SLEEP);
  assign polarity = (mode == ST_EXT) ? a_sync : pol;
  assign demod = ac_mode && !polarity;

  always_ff @(posedge mclk) begin
    if (rst) begin
      det_sample <= '0;
    end else begin
      det_sample.valid <= raw_sample.valid && sample_window;
      if (raw_sample.valid && sample_window) begin
        det_sample.data <= demod ? -raw_sample.data : raw_sample.data;
      end
    end
  end

  // A change while counting restarts the count
  always_ff @(posedge mclk) begin
    if (rst) begin
      settle_cnt <= '0;
    end else if (pol_evt) begin
      settle_cnt <= SETTLE_WORDS;
    end else if (det_sample.valid && settle_cnt != '0) begin
      settle_cnt <= settle_cnt - 3'h1;
    end
  end

  assign det_settled = (settle_cnt == '0);

  always_comb begin
    excitation_a_oe_n = 1'b0;
    unique case (mode)
      ST_SLEEP: begin
        excitation_out_a = 1'b1;
        excitation_out_b = 1'b0;
      end
      ST_EXT: begin
        excitation_a_oe_n = 1'b1;
        excitation_out_a = 1'b0;
        excitation_out_b = a_sync;
      end
      ST_ACTIVE: begin
        excitation_out_a = ~pol;
        excitation_out_b = pol;
      end
      default: begin
        excitation_out_a = 1'b0;
        excitation_out_b = 1'b1;
      end
    endcase
  end

  // Helper counters for the checks
  logic [7:0] since_chg;
  logic [CNT_W-1:0] run_len;
  logic [CNT_W-1:0] loaded_len;
  logic [1:0] loaded_sel;

  // Length and select in force for the running half; a select change
  // mid-half only applies at the next reload
  always_ff @(posedge mclk) begin
    if (rst) begin
      loaded_len <= '0;
      loaded_sel <= 2'h0;
    end else if (flip || mode != ST_ACTIVE) begin
      loaded_len <= half_len;
      loaded_sel <= excitation_select_field;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      since_chg <= 8'hff;
      run_len <= '0;
    end else begin
      if (pol_evt || mode == ST_SLEEP) begin
        since_chg <= 8'h01;
      end else if (since_chg != 8'hff) begin
        since_chg <= since_chg + 8'h01;
      end
      run_len <= (flip || mode != ST_ACTIVE) ? 16'h0001 : run_len + 16'h0001;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  window_after_holdoff_a: assert property (
    sample_window |-> since_chg > 8'h40)
    else $error("sampling window open within hold-off");
  window_opens_a: assert property (
    (since_chg == 8'h40) && !pol_evt && mode != ST_SLEEP && !sleep
      && $stable(mode) |=> sample_window)
    else $error("sampling window late after hold-off");
  equal_halves_a: assert property (
    flip && $past(mode) == ST_ACTIVE
      && run_len != 16'h0001 |-> run_len == loaded_len)
    else $error("half-period length wrong");
  khz_rate_a: assert property (
    flip && loaded_sel == 2'h1 && run_len != 16'h0001
      |-> run_len == HALF_P1)
    else $error("select one half-period wrong");
  pins_toggle_a: assert property (
    flip && next_mode == ST_ACTIVE
      |=> excitation_out_b != $past(excitation_out_b)
      && excitation_out_a == !excitation_out_b)
    else $error("square wave did not switch");
  stop_levels_a: assert property (
    !sleep && !ext_sel && excitation_select_field == SEL_STOP
      |=> excitation_out_b && !excitation_out_a && !excitation_a_oe_n)
    else $error("stopped excitation levels wrong");
  ext_follow_a: assert property (
    mode == ST_EXT |-> excitation_out_b == a_sync && excitation_a_oe_n)
    else $error("second output not following first pin");
  sleep_levels_a: assert property (
    sleep |=> (excitation_out_a && !excitation_out_b && !excitation_a_oe_n
      && !det_sample.valid) ##1 !det_sample.valid)
    else $error("sleep levels wrong");
  demod_sign_a: assert property (
    raw_sample.valid && sample_window && demod
      |=> det_sample.valid && det_sample.data == -$past(raw_sample.data))
    else $error("negative half not inverted");
  settle_flag_a: assert property (
    pol_evt |=> !det_settled ##0 settle_cnt == SETTLE_WORDS)
    else $error("settle count not restarted");

  flip_seen_c: cover property (
    flip && run_len != 16'h0001 && run_len == loaded_len);
  ext_edge_c: cover property (mode == ST_EXT && pol_evt);
  det_word_c: cover property (det_sample.valid && demod);
  sleep_c: cover property (mode == ST_ACTIVE ##1 mode == ST_SLEEP);

endmodule // bxs_sequencer

// ### verilog/bxs_pkg.sv
// Bridge excitation sequencer: shared constants, modes and carriers.
// Assumes one master clock; every count below except SETTLE_WORDS is in master clock cycles.
package bxs_pkg;

  // Divider counter width and the half-periods per select code
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] HALF_SEL1 = 16'h0800;
  localparam logic [CNT_W-1:0] HALF_SEL2 = 16'h0400;
  localparam logic [CNT_W-1:0] HALF_SEL3 = 16'h0200;

  // Sampling hold-off after a polarity change
  localparam int HOLD_W = 7;
  localparam logic [HOLD_W-1:0] HOLDOFF_CYC = 7'h40;

  // Converter output words that may be unsettled after a change
  localparam logic [2:0] SETTLE_WORDS = 3'h6;

  // Select code that stops switching
  localparam logic [1:0] SEL_STOP = 2'h0;

  // Reset level of the polarity (positive half, second output high)
  localparam logic POL_RESET = 1'b1;

  localparam int SAMPLE_W = 24;

  typedef enum logic [3:0] {
    ST_HOLD   = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_EXT    = 4'h4,
    ST_SLEEP  = 4'h8
  } bxs_mode_e;

  typedef struct packed {
    logic valid;
    logic signed [SAMPLE_W-1:0] data;
  } bxs_sample_s;

endpackage

// ### verilog/bxs_sync.sv
// Two-flop synchroniser for levels arriving from outside the mclk domain.
// Assumes the input is a slow level; no pulse is guaranteed to pass.
`timescale 1ns/1ps
module bxs_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge mclk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // bxs_sync

// ### bench/bxs_bridge_model.sv
// Far-side model: bridge driver and host on the first excitation pin.
// Assumes the host drives the pin only while the device releases it.
`timescale 1ns/1ps
module bxs_bridge_model (
  // Device side of the pin
  input wire logic excitation_out_a,
  input wire logic excitation_a_oe_n,
  // Level the host puts on the pin
  input wire logic host_level,
  // Resolved pin level
  output logic pin
);
  // Host toggles bridge polarity itself once the device lets go
  assign pin = excitation_a_oe_n ? host_level : excitation_out_a;
endmodule // bxs_bridge_model

// ### bench/bridge_excitation_sequencer_test.sv
// Self-checking bench for the bridge excitation sequencer.
// Assumes half-periods shortened to 100/80/70 cycles, 5 ns mclk.
`timescale 1ns/1ps
module bridge_excitation_sequencer_test;
  import bxs_pkg::*;
  logic mclk = 0, rst = 1, sleep = 0, ext_sel = 0, ac_mode = 0;
  logic host_level = 0, pin, out_a, oe_n, out_b;
  logic det_settled, polarity, sample_window;
  logic [1:0] sel = 2'h0;
  bxs_sample_s raw = '0, det;
  int n_errors = 0, tests_run = 0;
  int half[3] = '{100, 80, 70};
  always #2.5 mclk = ~mclk;
  bxs_sequencer #(.HALF_P1(16'h0064), .HALF_P2(16'h0050),
    .HALF_P3(16'h0046)) i_dut (.mclk(mclk), .rst(rst), .sleep(sleep),
    .ext_sel(ext_sel), .ac_mode(ac_mode), .excitation_select_field(sel),
    .excitation_a_in(pin), .excitation_out_a(out_a),
    .excitation_a_oe_n(oe_n), .excitation_out_b(out_b),
    .raw_sample(raw), .det_sample(det), .det_settled(det_settled),
    .polarity(polarity), .sample_window(sample_window));
  bxs_bridge_model i_model (.excitation_out_a(out_a),
    .excitation_a_oe_n(oe_n), .host_level(host_level), .pin(pin));
  task automatic step(int k = 1);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tmo(int n);
    if (n >= 3000) begin
      n_errors++;
      give_verdict();
    end
  endtask
  task automatic t_sleep();
    for (int m = 0; m < 2; m++) begin
      ac_mode = m[0];
      sleep = 1;
      step(2);
      chk("sleep out_a", out_a, 1);
      chk("sleep out_b", out_b, 0);
      chk("sleep window", sample_window, 0);
      sleep = 0;
      step(2);
      chk("stop out_b", out_b, 1);
      chk("stop out_a", out_a, 0);
    end
  endtask
  task automatic t_wave(int s);
    int n, w;
    logic b;
    sel = s[1:0];
    ac_mode = 1;
    b = out_b;
    for (n = 0; n < 3000 && out_b === b; n++) step();
    tmo(n);
    for (int h = 0; h < 2; h++) begin
      b = out_b;
      chk("window at flip", sample_window, 0);
      chk("polarity", polarity, out_b);
      w = 0;
      for (n = 0; n < 3000 && out_b === b; n++) begin
        if (sample_window === 1'b1 && w == 0) w = n;
        step();
      end
      tmo(n);
      chk("holdoff", w, 64);
      chk("half length", n, half[s-1]);
      chk("out_a complement", out_a, !out_b);
    end
  endtask
  task automatic t_demod();
    int n;
    for (int p = 0; p < 2; p++) begin
      for (n = 0; n < 3000 &&
           !(polarity === p[0] && sample_window === 1'b1); n++) step();
      tmo(n);
      raw = '{1'b1, 24'sh000005};
      step();
      raw = '0;
      chk("det valid", det.valid, 1);
      chk("det data", {8'h00, det.data}, p ? 32'h5 : 32'hfffffb);
      step();
      chk("det pulse", det.valid, 0);
    end
  endtask
  task automatic t_settle();
    int n;
    logic p;
    // Shorter half, and six words still fit inside one sampling window
    sel = 2'h2;
    p = polarity;
    for (n = 0; n < 3000 && polarity === p; n++) step();
    tmo(n);
    raw = '{1'b1, 24'sh000009};
    step();
    chk("settle low", det_settled, 0);
    chk("dropped", det.valid, 0);
    raw.valid = 0;
    for (n = 0; n < 3000 && sample_window !== 1'b1; n++) step();
    tmo(n);
    raw.valid = 1;
    step(5);
    chk("not settled", det_settled, 0);
    step();
    raw.valid = 0;
    step(3);
    chk("settled", det_settled, 1);
  endtask
  task automatic t_ext();
    ext_sel = 1;
    for (int i = 0; i < 4; i++) begin
      host_level = i[0];
      step(4);
      chk("released", oe_n, 1);
      chk("follow", out_b, i[0]);
    end
    sleep = 1;
    step(2);
    chk("ext sleep", out_a, 1);
    sleep = 0;
    ext_sel = 0;
    step(2);
  endtask
  // Host-switched dc bridge: offset 7, signal 0x100 at either polarity
  task automatic t_host();
    int n;
    logic signed [23:0] rd[2];
    ac_mode = 0;
    ext_sel = 1;
    host_level = 1;
    step(4);
    for (int p = 0; p < 2; p++) begin
      host_level = p[0];
      raw = '{1'b1, p ? 24'sh000107 : 24'shffff07};
      step(6);
      for (n = 0; n < 3000 && det_settled !== 1'b1; n++) step();
      tmo(n);
      chk("host word", {8'h00, det.data}, {8'h00, raw.data});
      rd[p] = det.data;
    end
    raw = '0;
    ext_sel = 0;
    step(2);
    chk("host average", (rd[1] - rd[0]) >>> 1, 32'h100);
  endtask
  initial begin
    step(8);
    chk("reset out_a", out_a, 0);
    chk("reset oe_n", oe_n, 0);
    chk("reset out_b", out_b, 1);
    rst = 0;
    step(2);
    t_sleep();
    for (int s = 1; s < 4; s++) t_wave(s);
    sel = 2'h1;
    t_demod();
    t_settle();
    t_ext();
    t_host();
    give_verdict();
  end
endmodule // bridge_excitation_sequencer_test
